//--- hdl/dbtc_pkg.sv
// Package with the register map, field positions and state of the timer.
package dbtc_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [15:0] DBTC_IDX_CONTROL    = 16'hFE10;
   localparam logic [15:0] DBTC_IDX_PRESCALER  = 16'hFE11;
   localparam logic [15:0] DBTC_IDX_COUNT_LOW  = 16'hFE12;
   localparam logic [15:0] DBTC_IDX_COUNT_HIGH = 16'hFE13;
   localparam logic [15:0] DBTC_IDX_MATCH_LOW  = 16'hFE14;
   localparam logic [15:0] DBTC_IDX_MATCH_HIGH = 16'hFE15;
   localparam logic [15:0] DBTC_IDX_CAPT_LOW   = 16'hFE16;
   localparam logic [15:0] DBTC_IDX_CAPT_HIGH  = 16'hFE17;
   localparam logic [17:0] DBTC_BASE_BYTE      = {DBTC_IDX_CONTROL, 2'b00};
   localparam int          DBTC_MIN_ADDR_W     = 18;

   // Control register fields.
   localparam int DBTC_BIT_HIGH_RUN    = 7;
   localparam int DBTC_BIT_LOW_RUN     = 6;
   localparam int DBTC_BIT_CASCADE     = 5;
   localparam int DBTC_BIT_LOW_EXT     = 4;
   localparam int DBTC_BIT_HIGH_FLAG   = 3;
   localparam int DBTC_BIT_HIGH_IE     = 2;
   localparam int DBTC_BIT_LOW_FLAG    = 1;
   localparam int DBTC_BIT_LOW_IE      = 0;

   // Values after reset, and the byte constants one and all ones.
   localparam logic [7:0]  DBTC_RST_BYTE    = 8'h00;
   localparam logic [7:0]  DBTC_BYTE_ONE    = 8'h01;
   localparam logic [7:0]  DBTC_BYTE_FULL   = 8'hFF;
   localparam logic [31:0] DBTC_RST_WORD    = 32'h0000_0000;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  prr;
      logic [7:0]  pcnt;
      logic [7:0]  cnt_l;
      logic [7:0]  cnt_h;
      logic [7:0]  data_l;
      logic [7:0]  data_h;
      logic [7:0]  buf_l;
      logic [7:0]  buf_h;
      logic [7:0]  cap_l;
      logic [7:0]  cap_h;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq_l;
      logic        irq_h;
   } dbtc_state_t;

   localparam dbtc_state_t DBTC_STATE_RST = '{
      ctrl: DBTC_RST_BYTE, prr: DBTC_RST_BYTE, pcnt: DBTC_RST_BYTE,
      cnt_l: DBTC_RST_BYTE, cnt_h: DBTC_RST_BYTE,
      data_l: DBTC_RST_BYTE, data_h: DBTC_RST_BYTE,
      buf_l: DBTC_RST_BYTE, buf_h: DBTC_RST_BYTE,
      cap_l: DBTC_RST_BYTE, cap_h: DBTC_RST_BYTE,
      prdata: DBTC_RST_WORD, pready: 1'b0, pslverr: 1'b0,
      irq_l: 1'b0, irq_h: 1'b0};

endpackage : dbtc_pkg

//--- hdl/dbtc_top.sv
// Dual byte timer/counter with prescaler, match buffers and capture on APB.
`timescale 1ns/1ns
`default_nettype none

module dbtc_top #(
   parameter int ADDR_W = 32
) (
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              deep_stop_i,
   input  wire logic              external_count_input_i,
   input  wire logic              low_capture_input_i,
   input  wire logic              high_capture_input_i,
   output logic                   low_irq_o,
   output logic                   high_irq_o
);
   import dbtc_pkg::*;

   if (ADDR_W < DBTC_MIN_ADDR_W || ADDR_W > 32)
   begin : g_addr_check
      $error("dbtc_top: ADDR_W must lie between 18 and 32");
   end

   dbtc_state_t s_r;
   dbtc_state_t s_nxt;

   localparam logic [ADDR_W-1:0] BASE_W = ADDR_W'(DBTC_BASE_BYTE);

   // One aligned word per register inside one 32 byte window.
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      addr_hit = (a[ADDR_W-1:5] == BASE_W[ADDR_W-1:5]) && (a[1:0] == 2'b00);
   endfunction : addr_hit

   function automatic logic sel_is(input logic [ADDR_W-1:0] a,
                                   input logic [15:0]       idx);
      sel_is = addr_hit(a) && (a[4:2] == idx[2:0]);
   endfunction : sel_is

   logic       acc_first;
   logic       wr_done;
   logic       pmatch;
   logic       prr_write;
   logic       run_l;
   logic       run_h;
   logic       cascade;
   logic       tick_l;
   logic       tick_h;
   logic       eq_l;
   logic       eq_h;
   logic       match_l;
   logic       match_h;
   logic [7:0] rd_byte;

   assign acc_first = psel_i & penable_i & ~s_r.pready;
   assign wr_done   = psel_i & penable_i & s_r.pready & pwrite_i;
   assign prr_write = wr_done & sel_is(paddr_i, DBTC_IDX_PRESCALER);

   assign run_l   = s_r.ctrl[DBTC_BIT_LOW_RUN];
   assign run_h   = s_r.ctrl[DBTC_BIT_HIGH_RUN];
   assign cascade = s_r.ctrl[DBTC_BIT_CASCADE];

   // Prescaler pulse is gated off in deep stop so no prescaled tick reaches the counters; external count pulses still do.
   assign pmatch = (s_r.pcnt == s_r.prr) & ~deep_stop_i;

   // External pulses are used as is; edge detection lives outside.
   assign tick_l = s_r.ctrl[DBTC_BIT_LOW_EXT] ?
                   external_count_input_i : pmatch;
   assign tick_h = cascade ? (tick_l & (s_r.cnt_l == DBTC_BYTE_FULL))
                           : pmatch;

   assign eq_l = (s_r.cnt_l == s_r.buf_l);
   assign eq_h = (s_r.cnt_h == s_r.buf_h);

   // In cascade the low byte owns the whole sixteen bit compare.
   assign match_l = run_l & tick_l & (cascade ? (eq_l & eq_h) : eq_l);
   assign match_h = cascade ? match_l : (run_h & tick_h & eq_h);

   always_comb
   begin
      rd_byte = DBTC_RST_BYTE;
      case (paddr_i[4:2])
         DBTC_IDX_CONTROL[2:0]:    rd_byte = s_r.ctrl;
         DBTC_IDX_PRESCALER[2:0]:  rd_byte = s_r.prr;
         DBTC_IDX_COUNT_LOW[2:0]:  rd_byte = s_r.cnt_l;
         DBTC_IDX_COUNT_HIGH[2:0]: rd_byte = s_r.cnt_h;
         DBTC_IDX_MATCH_LOW[2:0]:  rd_byte = s_r.data_l;
         DBTC_IDX_MATCH_HIGH[2:0]: rd_byte = s_r.data_h;
         DBTC_IDX_CAPT_LOW[2:0]:   rd_byte = s_r.cap_l;
         DBTC_IDX_CAPT_HIGH[2:0]:  rd_byte = s_r.cap_h;
         default:                  rd_byte = DBTC_RST_BYTE;
      endcase
   end

   always_comb
   begin
      s_nxt = s_r;

      // Bus answer: one wait state, error only for an unmapped address.
      s_nxt.pready  = acc_first;
      s_nxt.pslverr = acc_first & ~addr_hit(paddr_i);
      s_nxt.prdata  = (acc_first && addr_hit(paddr_i)) ?
                      {24'h000000, rd_byte} : DBTC_RST_WORD;

      // Prescaler.
      if (pmatch || prr_write)
      begin
         s_nxt.pcnt = DBTC_RST_BYTE;
      end
      else if (!deep_stop_i)
      begin
         s_nxt.pcnt = s_r.pcnt + DBTC_BYTE_ONE;
      end

      // Low byte counter and buffer.
      if (!run_l || match_l)
      begin
         s_nxt.cnt_l = DBTC_RST_BYTE;
         s_nxt.buf_l = s_r.data_l;
      end
      else if (tick_l)
      begin
         s_nxt.cnt_l = s_r.cnt_l + DBTC_BYTE_ONE;
      end

      // High byte counter and buffer.
      if (!run_h || match_h)
      begin
         s_nxt.cnt_h = DBTC_RST_BYTE;
         s_nxt.buf_h = s_r.data_h;
      end
      else if (tick_h)
      begin
         s_nxt.cnt_h = s_r.cnt_h + DBTC_BYTE_ONE;
      end

      // Captures see the count as it stands before this edge.
      if (cascade)
      begin
         if (high_capture_input_i)
         begin
            s_nxt.cap_l = s_r.cnt_l;
            s_nxt.cap_h = s_r.cnt_h;
         end
      end
      else
      begin
         if (low_capture_input_i)
         begin
            s_nxt.cap_l = s_r.cnt_l;
         end
         if (high_capture_input_i)
         begin
            s_nxt.cap_h = s_r.cnt_h;
         end
      end

      // Register writes take effect at the completing access edge.
      if (wr_done)
      begin
         if (sel_is(paddr_i, DBTC_IDX_CONTROL))
         begin
            s_nxt.ctrl = pwdata_i[7:0];
         end
         if (prr_write)
         begin
            s_nxt.prr = pwdata_i[7:0];
         end
         if (sel_is(paddr_i, DBTC_IDX_MATCH_LOW))
         begin
            s_nxt.data_l = pwdata_i[7:0];
         end
         if (sel_is(paddr_i, DBTC_IDX_MATCH_HIGH))
         begin
            s_nxt.data_h = pwdata_i[7:0];
         end
      end

      // A match in the same cycle as a clearing write still sets the flag.
      if (match_l)
      begin
         s_nxt.ctrl[DBTC_BIT_LOW_FLAG] = 1'b1;
      end
      if (match_h)
      begin
         s_nxt.ctrl[DBTC_BIT_HIGH_FLAG] = 1'b1;
      end

      s_nxt.irq_l = s_nxt.ctrl[DBTC_BIT_LOW_FLAG] &
                    s_nxt.ctrl[DBTC_BIT_LOW_IE];
      s_nxt.irq_h = s_nxt.ctrl[DBTC_BIT_HIGH_FLAG] &
                    s_nxt.ctrl[DBTC_BIT_HIGH_IE];
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_r <= DBTC_STATE_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign prdata_o   = s_r.prdata;
   assign pready_o   = s_r.pready;
   assign pslverr_o  = s_r.pslverr;
   assign low_irq_o  = s_r.irq_l;
   assign high_irq_o = s_r.irq_h;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   a_presc_restart: assert property (
      (pmatch || prr_write) |=> (s_r.pcnt == DBTC_RST_BYTE))
      else $error("prescaler did not restart at zero");

   a_presc_halt: assert property (
      (deep_stop_i && !prr_write) |=> $stable(s_r.pcnt) && !$past(pmatch))
      else $error("prescaler moved in deep stop");

   a_presc_period: assert property (
      (pmatch && !prr_write && (s_r.prr != DBTC_RST_BYTE))
      |=> !pmatch ##1 (s_r.pcnt == DBTC_BYTE_ONE ||
                       $past(deep_stop_i) || $past(prr_write)))
      else $error("prescaler count wrong after a match pulse");

   a_low_stopped: assert property (
      !run_l |=> (s_r.cnt_l == DBTC_RST_BYTE))
      else $error("stopped low counter not at zero");

   a_low_step: assert property (
      (run_l && tick_l && !match_l)
      |=> (s_r.cnt_l == 8'($past(s_r.cnt_l) + DBTC_BYTE_ONE)))
      else $error("low counter missed a count pulse");

   a_high_idle: assert property (
      (run_h && !tick_h && !match_h) |=> $stable(s_r.cnt_h))
      else $error("high counter moved without a tick");

   a_low_buffer: assert property (
      !run_l |=> (s_r.buf_l == $past(s_r.data_l)))
      else $error("low buffer did not follow its data");

   a_high_buffer: assert property (
      (run_h && !match_h) |=> $stable(s_r.buf_h))
      else $error("high buffer reloaded without a match");

   a_match_clear: assert property (
      match_h |=> (s_r.cnt_h == DBTC_RST_BYTE))
      else $error("high counter not cleared by match");

   a_flag_both: assert property (
      (cascade && match_l)
      |=> s_r.ctrl[DBTC_BIT_LOW_FLAG] && s_r.ctrl[DBTC_BIT_HIGH_FLAG])
      else $error("cascade match did not set both flags");

   a_capture_wide: assert property (
      (cascade && high_capture_input_i)
      |=> (s_r.cap_l == $past(s_r.cnt_l)) && (s_r.cap_h == $past(s_r.cnt_h)))
      else $error("wide capture lost a byte");

   a_irq_request: assert property (
      (match_l && s_r.ctrl[DBTC_BIT_LOW_IE] && !wr_done)
      |-> ##1 low_irq_o ##1 (low_irq_o || $past(wr_done)))
      else $error("low interrupt not raised on match");

   a_bus_answer: assert property (
      (psel_i && penable_i && !pready_o) |=> pready_o)
      else $error("bus access not answered after one wait");

   a_high_stopped: assert property (
      !run_h |=> (s_r.cnt_h == DBTC_RST_BYTE))
      else $error("stopped high counter not at zero");

   a_carry_step: assert property (
      (cascade && run_h && tick_h && !match_h)
      |=> (s_r.cnt_h == 8'($past(s_r.cnt_h) + DBTC_BYTE_ONE)))
      else $error("cascade carry did not step the high counter");

   a_low_clear: assert property (
      match_l |=> (s_r.cnt_l == DBTC_RST_BYTE))
      else $error("low counter not cleared by match");

   a_low_reload: assert property (
      match_l |=> (s_r.buf_l == $past(s_r.data_l)))
      else $error("low buffer not reloaded on match");

   a_low_hold: assert property (
      (run_l && !match_l) |=> $stable(s_r.buf_l))
      else $error("low buffer reloaded without a match");

   a_high_track: assert property (
      !run_h |=> (s_r.buf_h == $past(s_r.data_h)))
      else $error("high buffer did not follow its data");

   a_capture_low: assert property (
      (!cascade && low_capture_input_i)
      |=> (s_r.cap_l == $past(s_r.cnt_l)))
      else $error("low capture missed its count");

   a_capture_high: assert property (
      (!cascade && high_capture_input_i)
      |=> (s_r.cap_h == $past(s_r.cnt_h)))
      else $error("high capture missed its count");

   a_capture_keep: assert property (
      (cascade && !high_capture_input_i) |=> $stable(s_r.cap_l))
      else $error("low capture moved in cascade mode");

   a_flag_set: assert property (
      match_l |=> s_r.ctrl[DBTC_BIT_LOW_FLAG])
      else $error("low match did not set its flag");

   a_flag_hold: assert property (
      (s_r.ctrl[DBTC_BIT_HIGH_FLAG] && !wr_done)
      |=> s_r.ctrl[DBTC_BIT_HIGH_FLAG])
      else $error("high flag dropped without a write");

   a_irq_level: assert property (
      high_irq_o == (s_r.ctrl[DBTC_BIT_HIGH_FLAG] &&
                     s_r.ctrl[DBTC_BIT_HIGH_IE]))
      else $error("high interrupt line disagrees with flag and enable");

   // The answer is a one-cycle pulse, so error and data may stand only with it.
   a_bus_error: assert property (
      pslverr_o |-> pready_o)
      else $error("bus error raised outside a completing access");

   a_bus_idle: assert property (
      !pready_o |-> (prdata_o == DBTC_RST_WORD))
      else $error("read data not zero between accesses");

   c_mode0_low: cover property (
      !cascade && !s_r.ctrl[DBTC_BIT_LOW_EXT] && match_l);
   c_mode3_wide: cover property (
      cascade && s_r.ctrl[DBTC_BIT_LOW_EXT] && match_l && eq_h);
   c_capture_low: cover property (!cascade && low_capture_input_i && run_l);
   c_bus_error: cover property (pready_o && pslverr_o);
   c_mode1_ext: cover property (
      !cascade && s_r.ctrl[DBTC_BIT_LOW_EXT] && match_l);

endmodule : dbtc_top

`default_nettype wire

//--- dv/dbtc_pulse_model.sv
// Model of the pin edge detectors that feed count and capture pulses.
`timescale 1ns/1ns
`default_nettype none

module dbtc_pulse_model (
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   input  wire logic       run_i,
   input  wire logic [1:0] gap_i,
   input  wire logic       burst_go_i,
   input  wire logic [9:0] burst_len_i,
   input  wire logic       cap_lo_i,
   input  wire logic       cap_hi_i,
   output logic            count_o,
   output logic            cap_lo_o,
   output logic            cap_hi_o,
   output logic            busy_o
);
   logic [1:0] gap_r;
   logic [9:0] left_r;
   logic       fire;

   // Events are spaced gap_i+1 cycles apart, so gap_i must stay above 0.
   assign fire   = (gap_r == gap_i) && (run_i || left_r != 10'h000);
   assign busy_o = (left_r != 10'h000) || count_o;

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         gap_r    <= 2'h0;
         left_r   <= 10'h000;
         count_o  <= 1'b0;
         cap_lo_o <= 1'b0;
         cap_hi_o <= 1'b0;
      end
      else
      begin
         gap_r    <= (gap_r == gap_i) ? 2'h0 : gap_r + 2'h1;
         count_o  <= fire;
         cap_lo_o <= cap_lo_i;
         cap_hi_o <= cap_hi_i;
         if (burst_go_i)
            left_r <= burst_len_i;
         else if (fire && left_r != 10'h000)
            left_r <= left_r - 10'h001;
      end
   end
endmodule : dbtc_pulse_model

`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the dual byte timer/counter.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   import dbtc_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [17:0] paddr_i = 18'h00000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic        deep_stop_i = 1'b0;
   logic        run = 1'b0;
   logic [1:0]  gap = 2'h2;
   logic        go = 1'b0;
   logic [9:0]  blen = 10'h000;
   logic        cap_lo = 1'b0;
   logic        cap_hi = 1'b0;
   logic [31:0] prdata_o;
   logic        pready_o, pslverr_o, low_irq_o, high_irq_o, busy;
   logic        cnt_p, lo_p, hi_p;
   logic [9:0]  expq[$];
   int          fails = 0;
   int          cmp_count = 0;
   int          cyc = 0;

   dbtc_top #(.ADDR_W(18)) dbtc_top_inst (.clock_i, .rst_n_i, .psel_i,
      .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
      .pslverr_o, .deep_stop_i, .external_count_input_i(cnt_p),
      .low_capture_input_i(lo_p), .high_capture_input_i(hi_p),
      .low_irq_o, .high_irq_o);
   dbtc_pulse_model dbtc_pulse_model_inst (.clock_i, .rst_n_i, .run_i(run),
      .gap_i(gap), .burst_go_i(go), .burst_len_i(blen), .cap_lo_i(cap_lo),
      .cap_hi_i(cap_hi), .count_o(cnt_p), .cap_lo_o(lo_p),
      .cap_hi_o(hi_p), .busy_o(busy));

   initial
   begin
      forever #5 clock_i = ~clock_i;
   end

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic check_num(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : check_num

   task automatic check_apb(input logic [9:0] e);
      cmp_count++;
      if (pslverr_o !== e[8] || (e[9] && prdata_o !== {24'h000000, e[7:0]}))
      begin
         fails++;
         $display("wrong value at %0t: bus gave %h, want %h", $time,
                  {pslverr_o, prdata_o}, e);
      end
   endtask : check_apb

   // Each completed transfer retires the oldest expected answer.
   always @(posedge clock_i)
   begin
      cyc <= cyc + 1;
      if (psel_i && penable_i && pready_o === 1'b1 && expq.size() > 0)
         check_apb(expq.pop_front());
   end

   task automatic apb(input logic wr, input logic [15:0] idx,
                      input logic [7:0] d, input logic [7:0] exp,
                      input logic err);
      @(posedge clock_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= {idx, 2'h0};
      pwdata_i  <= {24'h000000, d};
      expq.push_back({~wr, err, exp});
      @(posedge clock_i);
      penable_i <= 1'b1;
      // The wait ends when pready_o rises; only the watchdog ends a wait that never gets it.
      do
         @(posedge clock_i);
      while (pready_o !== 1'b1);
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 8'h00, 1'b0);
   endtask : wr

   task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00, exp, 1'b0);
   endtask : rd

   task automatic wait_irq(output int t);
      do
         @(posedge clock_i);
      while (low_irq_o !== 1'b1);
      t = cyc;
   endtask : wait_irq

   task automatic burst(input logic [9:0] len);
      blen <= len;
      go   <= 1'b1;
      @(posedge clock_i);
      go <= 1'b0;
      do
         @(posedge clock_i);
      while (busy === 1'b1);
      repeat (2) @(posedge clock_i);
   endtask : burst

   task automatic pulse_cap(input logic hi);
      cap_lo <= ~hi;
      cap_hi <= hi;
      @(posedge clock_i);
      cap_lo <= 1'b0;
      cap_hi <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask : pulse_cap

   initial
   begin
      repeat (20000) @(posedge clock_i);
      fails++;
      report_and_stop();
   end

   initial
   begin : main
      int t1, t2, per, p, ml, rs;
      logic [1:0] m;
      rs = $urandom(87655);
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd(DBTC_IDX_CONTROL + 16'(i), 8'h00);
      apb(1'b0, DBTC_IDX_CAPT_HIGH + 16'h0001, 8'h00, 8'h00, 1'b1);
      wr(DBTC_IDX_COUNT_LOW, 8'h55);
      rd(DBTC_IDX_COUNT_LOW, 8'h00);
      wr(DBTC_IDX_CONTROL, 8'h0F);
      @(negedge clock_i);
      check_num({30'h0, high_irq_o, low_irq_o}, 32'h3);
      wr(DBTC_IDX_CONTROL, 8'h0E);
      rd(DBTC_IDX_CONTROL, 8'h0E);
      check_num({30'h0, high_irq_o, low_irq_o}, 32'h2);
      for (int k = 0; k < 4; k++)
      begin
         m = 2'(k);
         p = 1 + $urandom % 3;
         ml = 3 + $urandom % 4;
         gap <= 2'(1 + $urandom % 2);
         wr(DBTC_IDX_CONTROL, 8'h00);
         wr(DBTC_IDX_PRESCALER, 8'(p));
         wr(DBTC_IDX_MATCH_LOW, 8'(ml));
         wr(DBTC_IDX_MATCH_HIGH, 8'h01);
         run <= m[0];
         wr(DBTC_IDX_CONTROL, {2'h3, m, 4'h5});
         wait_irq(t1);
         if (m[1])
            check_num({31'h0, high_irq_o}, 32'h1);
         wr(DBTC_IDX_CONTROL, {2'h3, m, 4'h5});
         wait_irq(t2);
         per = ((m[1] ? 256 : 0) + ml + 1) * (m[0] ? gap + 1 : p + 1);
         check_num(t2 - t1, per);
      end
      wr(DBTC_IDX_CONTROL, 8'h00);
      run <= 1'b0;
      deep_stop_i <= 1'b1;
      wr(DBTC_IDX_CONTROL, 8'h40);
      repeat (10) @(posedge clock_i);
      rd(DBTC_IDX_COUNT_LOW, 8'h00);
      wr(DBTC_IDX_MATCH_LOW, 8'hFF);
      wr(DBTC_IDX_MATCH_HIGH, 8'hFF);
      // Stop first so the low count and its buffer restart from known values.
      wr(DBTC_IDX_CONTROL, 8'h00);
      deep_stop_i <= 1'b0;
      wr(DBTC_IDX_CONTROL, 8'h50);
      burst(10'h005);
      pulse_cap(1'b0);
      rd(DBTC_IDX_CAPT_LOW, 8'h05);
      wr(DBTC_IDX_CONTROL, 8'h00);
      rd(DBTC_IDX_COUNT_LOW, 8'h00);
      wr(DBTC_IDX_CONTROL, 8'hF0);
      burst(10'h105);
      pulse_cap(1'b1);
      rd(DBTC_IDX_CAPT_LOW, 8'h05);
      rd(DBTC_IDX_CAPT_HIGH, 8'h01);
      burst(10'h001);
      pulse_cap(1'b0);
      rd(DBTC_IDX_CAPT_LOW, 8'h05);
      report_and_stop();
   end
endmodule : tb_top

`default_nettype wire
